// ===== hw/circuit_one_alarm_monitor.sv
// alarm evaluation and protective actions for refrigeration circuit 1
// How it works
// - high suction alarm at reading >= threshold, clears at threshold minus differential
// - high condenser alarm after condenser delay above threshold, clears with differential
// - condenser alarm with stop option sheds compressors one step per stop-step delay
// - liquid level alarm after input delay while a function 109 input is active
// - liquid level alarm clears at once when that input goes inactive
// - superheat alarm at or below limit, action per setting, clears above limit plus release
// - suction probe alarm on fault of function 1 probe; compressors use fallbacks
// - condensing probe alarm on fault of function 3 probe
// - condensing probe alarm drives fans from the condenser fault fallback
// - both probe alarms clear as soon as the probe reads valid again
// - floodback alarm after superheat below limit for 90 minutes, clears above limit
// - floodback only warns: buzzer and alarm relay on, compressors keep running unless superheat action 1 stops them
// - booster configuration alarm while no circuit 1 compressor is available
// - booster configuration alarm clears once any compressor is available
`timescale 1ns/100ps
`default_nettype none
module circuit_one_alarm_monitor #(
    parameter int TICK_CYCLES = alarm_monitor_pkg::CLK_HZ,
    parameter int FLOOD_SECONDS = alarm_monitor_pkg::FLOOD_TIME_S
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire alarm_monitor_pkg::reading_t suction_reading,
    input wire logic suction_unit_is_temp,
    input wire alarm_monitor_pkg::reading_t suction_setpoint,
    input wire alarm_monitor_pkg::reading_t high_suction_offset,
    input wire logic suction_threshold_selection,
    input wire alarm_monitor_pkg::reading_t condenser_reading,
    input wire logic condenser_unit_is_temp,
    input wire alarm_monitor_pkg::reading_t condenser_setpoint,
    input wire alarm_monitor_pkg::reading_t high_condenser_offset,
    input wire logic condenser_threshold_selection,
    input wire alarm_monitor_pkg::seconds_t condenser_alarm_delay,
    input wire logic condenser_compressor_stop_option,
    input wire alarm_monitor_pkg::seconds_t compressor_stop_step_delay,
    input wire logic [7:0] di_active,
    input wire logic [7:0][7:0] digital_input_function,
    input wire alarm_monitor_pkg::seconds_t liquid_input_delay,
    input wire alarm_monitor_pkg::reading_t superheat,
    input wire alarm_monitor_pkg::reading_t superheat_limit,
    input wire alarm_monitor_pkg::reading_t superheat_release_differential,
    input wire logic [1:0] superheat_action_setting,
    input wire logic [3:0] ai_fault,
    input wire logic [3:0][7:0] analogue_input_function,
    input wire logic [7:0] suction_fault_fallback_a,
    input wire logic [7:0] suction_fault_fallback_b,
    input wire logic [7:0] condenser_fault_fallback,
    input wire logic [7:0] compressor_request,
    input wire logic [7:0] compressor_available,
    input wire logic [7:0] fan_request,
    output logic [7:0] compressor_enable,
    output logic [7:0] fan_enable,
    output logic high_suction_alarm,
    output logic high_condenser_alarm,
    output logic liquid_level_alarm,
    output logic superheat_alarm,
    output logic suction_probe_alarm,
    output logic condensing_probe_alarm,
    output logic floodback_alarm,
    output logic booster_configuration_alarm,
    output logic buzzer,
    output logic alarm_relay
);
    localparam logic [24:0] TICK_LAST = 25'(TICK_CYCLES - 1);
    localparam alarm_monitor_pkg::seconds_t FLOOD_LIMIT = 16'(FLOOD_SECONDS);

    // one-second time base
    logic [24:0] tick_cnt_reg, tick_cnt_next;
    logic sec_tick;
    always_comb begin
        sec_tick = (tick_cnt_reg == TICK_LAST);
        tick_cnt_next = sec_tick ? alarm_monitor_pkg::TICK_ZERO : tick_cnt_reg + 25'h0000001;
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) tick_cnt_reg <= alarm_monitor_pkg::TICK_ZERO;
        else tick_cnt_reg <= tick_cnt_next;
    end

    // input decoding
    logic liquid_in, suction_fault_in, cond_fault_in;
    logic [7:0] di_match;
    logic [3:0] ai_suc, ai_cond;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_di
            assign di_match[gi] = di_active[gi] &&
                (digital_input_function[gi] == alarm_monitor_pkg::DI_LIQUID_LEVEL);
        end
        for (gi = 0; gi < 4; gi++) begin : g_ai
            assign ai_suc[gi] = ai_fault[gi] && (analogue_input_function[gi] == alarm_monitor_pkg::AI_SUCTION);
            assign ai_cond[gi] = ai_fault[gi] && (analogue_input_function[gi] == alarm_monitor_pkg::AI_CONDENSING);
        end
    endgenerate
    assign liquid_in = |di_match;
    assign suction_fault_in = |ai_suc;
    assign cond_fault_in = |ai_cond;

    // thresholds
    alarm_monitor_pkg::wide_t hs_thr, hs_rel, hc_thr, hc_rel, suc_w, cond_w, sh_w, sh_lim, sh_rel;
    always_comb begin
        suc_w = 17'(suction_reading);
        cond_w = 17'(condenser_reading);
        sh_w = 17'(superheat);
        sh_lim = 17'(superheat_limit);
        sh_rel = sh_lim + 17'(superheat_release_differential);
        hs_thr = suction_threshold_selection ? 17'(high_suction_offset)
                                             : 17'(suction_setpoint) + 17'(high_suction_offset);
        hs_rel = hs_thr - (suction_unit_is_temp ? alarm_monitor_pkg::DIFF_TEMP : alarm_monitor_pkg::DIFF_BAR);
        hc_thr = condenser_threshold_selection ? 17'(high_condenser_offset)
                                               : 17'(condenser_setpoint) + 17'(high_condenser_offset);
        hc_rel = hc_thr - (condenser_unit_is_temp ? alarm_monitor_pkg::DIFF_TEMP : alarm_monitor_pkg::DIFF_BAR);
    end

    // counts whole seconds while the condition holds, saturating
    function automatic alarm_monitor_pkg::seconds_t sec_count(input logic cond,
            input alarm_monitor_pkg::seconds_t cnt, input logic tick);
        alarm_monitor_pkg::seconds_t r;
        r = cnt;
        if (!cond) r = alarm_monitor_pkg::SEC_ZERO;
        else if (tick && cnt != 16'hffff) r = cnt + 16'h0001;
        return r;
    endfunction

    // the free running time base may cut the first second short,
    // so a delay of d seconds waits for d+1 ticks; zero means at once
    function automatic logic elapsed(input alarm_monitor_pkg::seconds_t cnt,
            input alarm_monitor_pkg::seconds_t limit);
        return (limit == alarm_monitor_pkg::SEC_ZERO) || (cnt > limit) || (cnt == 16'hffff);
    endfunction

    // alarm flags and their timers
    logic hs_reg, hs_next, hc_reg, hc_next, ll_reg, ll_next, sh_reg, sh_next;
    logic fb_reg, fb_next, sp_reg, sp_next, cp_reg, cp_next, bo_reg, bo_next;
    alarm_monitor_pkg::seconds_t hc_cnt_reg, hc_cnt_next, ll_cnt_reg, ll_cnt_next, fb_cnt_reg, fb_cnt_next;
    always_comb begin
        hs_next = hs_reg;
        if (suc_w >= hs_thr) hs_next = 1'b1;
        else if (suc_w <= hs_rel) hs_next = 1'b0;

        hc_cnt_next = sec_count(cond_w >= hc_thr, hc_cnt_reg, sec_tick);
        hc_next = hc_reg;
        if (cond_w >= hc_thr && elapsed(hc_cnt_reg, condenser_alarm_delay)) hc_next = 1'b1;
        else if (cond_w <= hc_rel) hc_next = 1'b0;

        ll_cnt_next = sec_count(liquid_in, ll_cnt_reg, sec_tick);
        ll_next = liquid_in && (ll_reg || elapsed(ll_cnt_reg, liquid_input_delay));

        sh_next = sh_reg;
        if (sh_w <= sh_lim) sh_next = 1'b1;
        else if (sh_w > sh_rel) sh_next = 1'b0;

        fb_cnt_next = sec_count(sh_w < sh_lim, fb_cnt_reg, sec_tick);
        fb_next = fb_reg;
        if (sh_w < sh_lim && elapsed(fb_cnt_reg, FLOOD_LIMIT)) fb_next = 1'b1;
        else if (sh_w > sh_lim) fb_next = 1'b0;

        sp_next = suction_fault_in;
        cp_next = cond_fault_in;
        bo_next = ~|compressor_available;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            hs_reg <= 1'b0;
            hc_reg <= 1'b0;
            ll_reg <= 1'b0;
            sh_reg <= 1'b0;
            fb_reg <= 1'b0;
            sp_reg <= 1'b0;
            cp_reg <= 1'b0;
            bo_reg <= 1'b0;
            hc_cnt_reg <= alarm_monitor_pkg::SEC_ZERO;
            ll_cnt_reg <= alarm_monitor_pkg::SEC_ZERO;
            fb_cnt_reg <= alarm_monitor_pkg::SEC_ZERO;
        end else begin
            hs_reg <= hs_next;
            hc_reg <= hc_next;
            ll_reg <= ll_next;
            sh_reg <= sh_next;
            fb_reg <= fb_next;
            sp_reg <= sp_next;
            cp_reg <= cp_next;
            bo_reg <= bo_next;
            hc_cnt_reg <= hc_cnt_next;
            ll_cnt_reg <= ll_cnt_next;
            fb_cnt_reg <= fb_cnt_next;
        end
    end

    // stepwise compressor shedding on high condenser alarm
    alarm_monitor_pkg::shed_state_t shed_reg, shed_next;
    logic [7:0] allow_reg, allow_next, running, lowest;
    alarm_monitor_pkg::seconds_t step_cnt_reg, step_cnt_next;
    always_comb begin
        shed_next = shed_reg;
        allow_next = allow_reg;
        step_cnt_next = step_cnt_reg;
        running = compressor_enable & allow_reg;
        lowest = running & (~running + 8'h01);
        unique case (shed_reg)
            alarm_monitor_pkg::SHED_IDLE: begin
                if (hc_reg && condenser_compressor_stop_option) begin
                    shed_next = alarm_monitor_pkg::SHED_ACTIVE;
                    allow_next = allow_reg & ~lowest;
                    step_cnt_next = alarm_monitor_pkg::SEC_ZERO;
                end
            end
            alarm_monitor_pkg::SHED_ACTIVE: begin
                if (!hc_reg || !condenser_compressor_stop_option) begin
                    shed_next = alarm_monitor_pkg::SHED_IDLE;
                    allow_next = alarm_monitor_pkg::ALLOW_ALL;
                end else if (elapsed(step_cnt_reg, compressor_stop_step_delay)) begin
                    allow_next = allow_reg & ~lowest;
                    step_cnt_next = alarm_monitor_pkg::SEC_ZERO;
                end else if (sec_tick) begin
                    step_cnt_next = step_cnt_reg + 16'h0001;
                end
            end
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            shed_reg <= alarm_monitor_pkg::SHED_IDLE;
            allow_reg <= alarm_monitor_pkg::ALLOW_ALL;
            step_cnt_reg <= alarm_monitor_pkg::SEC_ZERO;
        end else begin
            shed_reg <= shed_next;
            allow_reg <= allow_next;
            step_cnt_reg <= step_cnt_next;
        end
    end

    // registered outputs
    logic [7:0] comp_next, fan_next, comp_base;
    logic buzz_next, relay_next;
    always_comb begin
        // fallbacks a force on, b force off while the suction probe is lost
        comp_base = sp_next ? ((compressor_request | suction_fault_fallback_a) & ~suction_fault_fallback_b)
                            : compressor_request;
        comp_next = comp_base & compressor_available & allow_next;
        if (sh_next && superheat_action_setting == alarm_monitor_pkg::SH_ACTION_STOP) comp_next = 8'h00;
        fan_next = cp_next ? condenser_fault_fallback : fan_request;
        // floodback never touches compressors, it only signals
        buzz_next = fb_next || hs_next || hc_next || ll_next || sh_next || sp_next || cp_next || bo_next;
        relay_next = buzz_next;
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            compressor_enable <= 8'h00;
            fan_enable <= 8'h00;
            buzzer <= 1'b0;
            alarm_relay <= 1'b0;
        end else begin
            compressor_enable <= comp_next;
            fan_enable <= fan_next;
            buzzer <= buzz_next;
            alarm_relay <= relay_next;
        end
    end
    assign high_suction_alarm = hs_reg;
    assign high_condenser_alarm = hc_reg;
    assign liquid_level_alarm = ll_reg;
    assign superheat_alarm = sh_reg;
    assign suction_probe_alarm = sp_reg;
    assign condensing_probe_alarm = cp_reg;
    assign floodback_alarm = fb_reg;
    assign booster_configuration_alarm = bo_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence liquid_drop_s;
        liquid_level_alarm ##0 !liquid_in;
    endsequence
    sequence shed_start_s;
        $rose(high_condenser_alarm) && condenser_compressor_stop_option && |(compressor_enable & allow_reg);
    endsequence

    chk_high_suction_set: assert property (suc_w >= hs_thr |=> high_suction_alarm)
        else $error("high suction alarm missed");
    chk_high_suction_clear: assert property (suc_w <= hs_rel && suc_w < hs_thr |=> !high_suction_alarm)
        else $error("high suction alarm not released");
    chk_condenser_release: assert property (cond_w <= hc_rel && cond_w < hc_thr |=> !high_condenser_alarm)
        else $error("high condenser alarm not released");
    chk_condenser_wait: assert property (!high_condenser_alarm && cond_w < hc_thr |=> !high_condenser_alarm)
        else $error("high condenser alarm without cause");
    chk_shed_first_step: assert property (shed_start_s |=> $countones(allow_reg) == $countones($past(allow_reg)) - 1)
        else $error("first shed step missing");
    chk_liquid_clear: assert property (liquid_drop_s |=> !liquid_level_alarm)
        else $error("liquid level alarm held without input");
    chk_superheat_set: assert property (sh_w <= sh_lim |=> superheat_alarm)
        else $error("superheat alarm missed");
    chk_probe_follow: assert property (suction_fault_in != suction_probe_alarm |=> suction_probe_alarm == $past(suction_fault_in))
        else $error("suction probe alarm lags");
    chk_fan_fallback: assert property (cond_fault_in |=> fan_enable == $past(condenser_fault_fallback))
        else $error("fan fallback not applied");
    chk_flood_warning: assert property (floodback_alarm |-> buzzer && alarm_relay)
        else $error("floodback without warning");
    chk_flood_release: assert property (sh_w > sh_lim |=> !floodback_alarm)
        else $error("floodback alarm not released");
    chk_booster_track: assert property (~|compressor_available |=> booster_configuration_alarm ##1 1)
        else $error("booster alarm missed");
    chk_booster_clear: assert property (|compressor_available |=> !booster_configuration_alarm)
        else $error("booster alarm not released");
endmodule // circuit_one_alarm_monitor
`default_nettype wire

// ===== hw/alarm_monitor_pkg.sv
// constants and types for the circuit 1 alarm monitor
package alarm_monitor_pkg;
    // readings are signed tenths of a bar or of a degree
    typedef logic signed [15:0] reading_t;
    typedef logic signed [16:0] wide_t;
    typedef logic [7:0] func_code_t;
    typedef logic [15:0] seconds_t;

    localparam int NUM_COMP = 8;
    localparam int NUM_FANS = 8;
    localparam int NUM_DI = 8;
    localparam int NUM_AI = 4;

    // release differentials in tenths: 0.3 bar and 1 degree
    localparam wide_t DIFF_BAR = 17'sh00003;
    localparam wide_t DIFF_TEMP = 17'sh0000a;

    // configured input functions
    localparam func_code_t DI_LIQUID_LEVEL = 8'h6d;
    localparam func_code_t AI_SUCTION = 8'h01;
    localparam func_code_t AI_CONDENSING = 8'h03;

    // superheat action: 0 signals only, 1 also stops compressors
    localparam logic [1:0] SH_ACTION_STOP = 2'h1;

    // clock and time base
    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_PERIOD_NS = 40;
    localparam int FLOOD_TIME_MIN = 90;
    localparam int FLOOD_TIME_S = FLOOD_TIME_MIN * 60;
    localparam int TICK_W = 25;

    // reset values
    localparam logic [NUM_COMP-1:0] ALLOW_ALL = 8'hff;
    localparam seconds_t SEC_ZERO = 16'h0000;
    localparam logic [TICK_W-1:0] TICK_ZERO = 25'h0000000;

    typedef enum logic [1:0] {
        SHED_IDLE = 2'b01,
        SHED_ACTIVE = 2'b10
    } shed_state_t;
endpackage

// ===== tb/probe_model.sv
// probe and switch model standing in front of the alarm monitor
`timescale 1ns/100ps
`default_nettype none
module probe_model (
    input wire logic ref_clk,
    input wire logic signed [15:0] s_tgt,
    input wire logic signed [15:0] c_tgt,
    input wire logic signed [15:0] sh_tgt,
    input wire logic [3:0] fail,
    output logic signed [15:0] suction_reading,
    output logic signed [15:0] condenser_reading,
    output logic signed [15:0] superheat,
    output logic [3:0] ai_fault
);
    // a failed probe reads bottom of scale, not its last good value
    always_ff @(posedge ref_clk) begin
        suction_reading <= fail[0] ? 16'sh8000 : s_tgt;
        condenser_reading <= fail[1] ? 16'sh8000 : c_tgt;
        superheat <= sh_tgt;
        ai_fault <= fail;
    end
endmodule // probe_model
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the circuit 1 alarm monitor
`timescale 1ns/100ps
`default_nettype none
module testbench;
    typedef struct {int s; logic [7:0] e;} note_t;
    logic ref_clk = 1'b0, nrst = 1'b0, tgot;
    logic suction_unit_is_temp = 1'b0, suction_threshold_selection = 1'b0;
    logic condenser_unit_is_temp = 1'b0, condenser_threshold_selection = 1'b0;
    logic condenser_compressor_stop_option = 1'b1;
    alarm_monitor_pkg::reading_t suction_setpoint = 16'sh0064, high_suction_offset = 16'sh0014;
    alarm_monitor_pkg::reading_t condenser_setpoint = 16'sh00c8, high_condenser_offset = 16'sh0032;
    alarm_monitor_pkg::reading_t superheat_limit = 16'sh0032, superheat_release_differential = 16'sh0014;
    alarm_monitor_pkg::reading_t s_tgt = 16'sh0000, c_tgt = 16'sh0000, sh_tgt = 16'sh0064;
    alarm_monitor_pkg::reading_t suction_reading, condenser_reading, superheat;
    alarm_monitor_pkg::seconds_t condenser_alarm_delay = 16'h0002, compressor_stop_step_delay = 16'h0002;
    alarm_monitor_pkg::seconds_t liquid_input_delay = 16'h0002;
    logic [7:0] di_active = 8'h00, suction_fault_fallback_a = 8'h30, suction_fault_fallback_b = 8'h03;
    logic [7:0] condenser_fault_fallback = 8'ha5, compressor_request = 8'hff, compressor_available = 8'hff;
    logic [7:0] fan_request = 8'h0f, compressor_enable, fan_enable;
    logic [7:0][7:0] digital_input_function = 64'h00000000006d0000;
    logic [3:0][7:0] analogue_input_function = 32'h07000301;
    logic [1:0] superheat_action_setting = 2'h1;
    logic [3:0] ai_fault, fail = 4'h0;
    logic high_suction_alarm, high_condenser_alarm, liquid_level_alarm, superheat_alarm;
    logic suction_probe_alarm, condensing_probe_alarm, floodback_alarm, booster_configuration_alarm;
    logic buzzer, alarm_relay;
    int fail_count = 0, n_tests = 0, seed = 32'hfa649d30;
    note_t q[$];
    event got_note;

    probe_model probe_model_inst (.ref_clk(ref_clk), .s_tgt(s_tgt), .c_tgt(c_tgt), .sh_tgt(sh_tgt),
        .fail(fail), .suction_reading(suction_reading), .condenser_reading(condenser_reading),
        .superheat(superheat), .ai_fault(ai_fault));
    circuit_one_alarm_monitor #(.TICK_CYCLES(4), .FLOOD_SECONDS(3)) circuit_one_alarm_monitor_inst (.*);

    always #20 ref_clk = ~ref_clk;

    function automatic logic [7:0] pick(input int s);
        logic [9:0] f;
        f = {alarm_relay, buzzer, booster_configuration_alarm, floodback_alarm, condensing_probe_alarm,
            suction_probe_alarm, superheat_alarm, liquid_level_alarm, high_condenser_alarm, high_suction_alarm};
        if (s == 10) return compressor_enable;
        if (s == 11) return fan_enable;
        if (s == 12) return {7'h00, tgot};
        return {7'h00, f[s]};
    endfunction

    task automatic compare_val(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %0t output got %h want %h", $time, g, e);
        end
    endtask

    task automatic give_verdict;
        if (fail_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // monitor: checks every queued note, oldest first, whenever a result is announced
    initial forever begin
        @(got_note);
        while (q.size() > 0) begin
            compare_val(pick(q[0].s), q[0].e);
            void'(q.pop_front());
        end
    end

    task automatic note(input int s, input logic [7:0] e);
        q.push_back('{s, e});
        -> got_note;
    endtask

    task automatic settle;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    // waits for output s to reach v and notes whether it took lo..hi-1 cycles
    task automatic timed(input int s, input logic [7:0] v, input int lo, input int hi);
        int n;
        n = 0;
        while (pick(s) !== v && n < hi) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        tgot = (n >= lo && n < hi);
        note(12, 8'h01);
    endtask

    task automatic drive_s(input alarm_monitor_pkg::reading_t v, input logic e);
        @(posedge ref_clk);
        s_tgt <= v;
        settle;
        note(0, {7'h00, e});
    endtask

    initial begin
        #100000;
        fail_count++;
        give_verdict;
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (4) begin
            @(posedge ref_clk);
            fan_request <= 8'($random(seed));
            compressor_request <= 8'($random(seed));
            settle;
            note(11, fan_request);
            note(10, compressor_request);
        end
        compressor_request <= 8'hff;
        drive_s(16'sh0077, 1'b0);
        drive_s(16'sh0078, 1'b1);
        note(8, 8'h01);
        drive_s(16'sh0076, 1'b1);
        drive_s(16'sh0075, 1'b0);
        suction_threshold_selection <= 1'b1;
        suction_unit_is_temp <= 1'b1;
        drive_s(16'sh0014, 1'b1);
        drive_s(16'sh000b, 1'b1);
        drive_s(16'sh000a, 1'b0);
        @(posedge ref_clk);
        c_tgt <= 16'sh00fa;
        // 2 s of 4 cycles plus probe and flag latency, at most one extra second
        timed(1, 8'h01, 10, 15);
        timed(10, 8'hfe, 0, 4);
        timed(10, 8'hfc, 8, 14);
        c_tgt <= 16'sh00f8;
        settle;
        note(1, 8'h01);
        c_tgt <= 16'sh00f7;
        settle;
        note(1, 8'h00);
        note(10, 8'hff);
        di_active <= 8'h08;
        settle;
        note(2, 8'h00);
        di_active <= 8'h04;
        timed(2, 8'h01, 9, 14);
        di_active <= 8'h00;
        settle;
        note(2, 8'h00);
        sh_tgt <= 16'sh0032;
        settle;
        note(3, 8'h01);
        note(10, 8'h00);
        sh_tgt <= 16'sh0046;
        settle;
        note(3, 8'h01);
        sh_tgt <= 16'sh0047;
        settle;
        note(3, 8'h00);
        note(10, 8'hff);
        superheat_action_setting <= 2'h0;
        sh_tgt <= 16'sh0028;
        timed(6, 8'h01, 14, 19);
        note(10, 8'hff);
        note(8, 8'h01);
        note(9, 8'h01);
        sh_tgt <= 16'sh0033;
        settle;
        note(6, 8'h00);
        note(3, 8'h01);
        sh_tgt <= 16'sh0064;
        settle;
        note(3, 8'h00);
        note(9, 8'h00);
        compressor_request <= 8'h0f;
        fail <= 4'h3;
        settle;
        note(4, 8'h01);
        note(5, 8'h01);
        note(10, 8'h3c);
        note(11, 8'ha5);
        fail <= 4'hc;
        settle;
        note(4, 8'h00);
        note(5, 8'h00);
        note(10, 8'h0f);
        note(11, fan_request);
        compressor_available <= 8'h00;
        settle;
        note(7, 8'h01);
        compressor_available <= 8'h10;
        settle;
        note(7, 8'h00);
        // absolute temperature threshold, no delay, no shedding, then a reset in mid-run
        compressor_request <= 8'hff;
        condenser_compressor_stop_option <= 1'b0;
        condenser_alarm_delay <= 16'h0000;
        condenser_threshold_selection <= 1'b1;
        condenser_unit_is_temp <= 1'b1;
        c_tgt <= 16'sh0032;
        settle;
        note(1, 8'h01);
        note(10, 8'h10);
        @(posedge ref_clk);
        nrst <= 1'b0;
        settle;
        note(1, 8'h00);
        note(8, 8'h00);
        @(posedge ref_clk);
        nrst <= 1'b1;
        settle;
        note(1, 8'h01);
        c_tgt <= 16'sh0029;
        settle;
        note(1, 8'h01);
        c_tgt <= 16'sh0028;
        settle;
        note(1, 8'h00);
        #1;
        give_verdict;
    end
endmodule // testbench
`default_nettype wire
